// file: src/jesd_sync_pkg.sv
// constants and carrier types for the lane synchronisation timing block
// assumes one 10 MHz clock; one frame lasts a fixed number of clock cycles
package jesd_sync_pkg;

  // frame and multiframe timing, in clock cycles
  localparam int FRAME_CYC = 10;
  localparam int FRAMES_PER_MF = 16;
  localparam int MF_CYC = FRAME_CYC * FRAMES_PER_MF;

  // launch delay after the local multiframe boundary, in tenths of a frame
  localparam int TX_DLY_TENTHS = 66;
  localparam int TX_DLY_CYC = (TX_DLY_TENTHS * FRAME_CYC) / 10;
  localparam logic [7:0] TX_OFS = 8'(TX_DLY_CYC);
  // transmit counters at the cycle the local boundary is forced to zero
  localparam logic [3:0] TX_REALIGN_FRAME =
    4'((MF_CYC - TX_DLY_CYC) / FRAME_CYC);
  localparam logic [3:0] TX_REALIGN_SUB =
    4'((MF_CYC - TX_DLY_CYC) % FRAME_CYC);
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_CYC - 1);
  localparam logic [3:0] MF_LAST_FRAME = 4'(FRAMES_PER_MF - 1);
  localparam logic [7:0] MF_LAST_POS = 8'(MF_CYC - 1);

  // resync request: minimum low time of the sync input, in frames
  localparam int RESYNC_FRAMES = 4;
  localparam logic [7:0] RESYNC_CYC = 8'(RESYNC_FRAMES * FRAME_CYC);

  // index of the last alignment multiframe; the sequence lasts 4 multiframes
  localparam logic [1:0] ILA_LAST_MF = 2'h3;

  // sysref latch to boundary delay, in tenths of a frame per divider
  localparam int SR_DIV1_TENTHS = 40;
  localparam int SR_DIV2_TENTHS = 50;
  localparam int SR_DIV4_TENTHS = 45;
  localparam logic [7:0] SR_DIV1_CYC = 8'((SR_DIV1_TENTHS * FRAME_CYC) / 10);
  localparam logic [7:0] SR_DIV2_CYC = 8'((SR_DIV2_TENTHS * FRAME_CYC) / 10);
  localparam logic [7:0] SR_DIV4_CYC = 8'((SR_DIV4_TENTHS * FRAME_CYC) / 10);

  // input clock divider select encoding
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;

  // control characters
  localparam logic [7:0] K_COMMA = 8'hBC;
  localparam logic [7:0] K_MF_START = 8'h1C;
  localparam logic [7:0] K_MF_END = 8'h7C;
  localparam logic [7:0] K_CFG_START = 8'h9C;

  // link configuration octets; identifiers are arbitrary values
  localparam logic [7:0] CFG_DEV_ID = 8'h5A;
  localparam logic [3:0] CFG_BANK_ID = 4'h3;
  localparam logic [7:0] CFG_LANES_M1 = 8'h01;
  localparam logic [7:0] CFG_OCTETS_M1 = 8'h01;
  localparam logic [7:0] CFG_K_M1 = 8'(FRAMES_PER_MF - 1);
  localparam logic [7:0] CFG_CONV_M1 = 8'h00;
  localparam logic [7:0] CFG_RES_M1 = 8'h0F;
  localparam logic [7:0] CFG_SUBCLASS_NT = 8'h2F;
  localparam logic [7:0] CFG_VER_S = 8'h20;
  localparam int LANES = 2;

  typedef struct packed {
    logic k;
    logic [7:0] d;
  } lane_char_t;

  typedef enum logic [2:0] {
    PH_CGS = 3'b001,
    PH_ILA = 3'b010,
    PH_DATA = 3'b100
  } link_phase_t;

endpackage

// file: src/ila_char_gen.sv
// per-lane character selection for one transmit frame
// assumes the caller registers the result on the frame start
`timescale 1ns/1ps
`default_nettype none
module ila_char_gen
(
  // link position
  input wire jesd_sync_pkg::link_phase_t phase_i,
  input wire logic [1:0] ila_mf_i,
  input wire logic [3:0] frame_i,
  // sample to send in data phase
  input wire logic [15:0] sample_i,
  // characters for each lane
  output jesd_sync_pkg::lane_char_t [1:0] chars_o
);

  function automatic logic [7:0] cfg_octet(input logic [3:0] idx,
                                           input logic [4:0] lid);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      4'h0: v = jesd_sync_pkg::CFG_DEV_ID;
      4'h1: v = {4'h0, jesd_sync_pkg::CFG_BANK_ID};
      4'h2: v = {3'h0, lid};
      4'h3: v = jesd_sync_pkg::CFG_LANES_M1;
      4'h4: v = jesd_sync_pkg::CFG_OCTETS_M1;
      4'h5: v = jesd_sync_pkg::CFG_K_M1;
      4'h6: v = jesd_sync_pkg::CFG_CONV_M1;
      4'h7: v = jesd_sync_pkg::CFG_RES_M1;
      4'h8: v = jesd_sync_pkg::CFG_SUBCLASS_NT;
      4'h9: v = jesd_sync_pkg::CFG_VER_S;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] cfg_sum(input logic [4:0] lid);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 12; i++)
    begin
      s = s + cfg_octet(4'(i), lid);
    end
    return s;
  endfunction

  genvar g;
  generate
    for (g = 0; g < jesd_sync_pkg::LANES; g++)
    begin : g_lane
      localparam logic [4:0] LID = 5'(g);
      always_comb
      begin
        chars_o[g] = '0;
        case (phase_i)
          jesd_sync_pkg::PH_CGS:
          begin
            chars_o[g] = '{k: 1'b1, d: jesd_sync_pkg::K_COMMA};
          end
          jesd_sync_pkg::PH_ILA:
          begin
            // ramp filler, then fixed markers
            chars_o[g] = '{k: 1'b0, d: {2'h0, ila_mf_i, frame_i}};
            if (frame_i == 4'h0)
            begin
              chars_o[g] = '{k: 1'b1, d: jesd_sync_pkg::K_MF_START};
            end
            else if (frame_i == jesd_sync_pkg::MF_LAST_FRAME)
            begin
              chars_o[g] = '{k: 1'b1, d: jesd_sync_pkg::K_MF_END};
            end
            else if (ila_mf_i == 2'h1 && frame_i == 4'h1)
            begin
              chars_o[g] = '{k: 1'b1, d: jesd_sync_pkg::K_CFG_START};
            end
            else if (ila_mf_i == 2'h1 && frame_i == 4'hE)
            begin
              chars_o[g] = '{k: 1'b0, d: cfg_sum(LID)};
            end
            else if (ila_mf_i == 2'h1)
            begin
              chars_o[g] = '{k: 1'b0, d: cfg_octet(frame_i - 4'h2, LID)};
            end
          end
          jesd_sync_pkg::PH_DATA:
          begin
            // lane 0 carries the upper octet of the sample
            chars_o[g] = '{k: 1'b0, d: sample_i[15 - 8 * g -: 8]};
          end
          default: chars_o[g] = '0;
        endcase
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: src/jesd_link_sync_timing.sv
// transmit-side link synchronisation timing for a two-lane serial output
// assumes the sync input and sysref come from pins (async to mclk_i);
// divider select and sample come from logic on mclk_i
//
// Function
// - the first comma frame after a resync starts 6.6 frames after the preceding boundary; after reset it starts 0.6 frames after it.
// - the first alignment frame starts 6.6 frames after the preceding boundary.
// - the first data frame starts 6.6 frames after the preceding boundary.
// - the alignment sequence lasts exactly 4 multiframes before data.
// - the boundary at which sync is seen released picks the alignment start.
// - a latched sysref realigns the boundary 4 frames later at divide by one.
`timescale 1ns/1ps
`default_nettype none
module jesd_link_sync_timing
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // link control pins
  input wire logic syncb_n_i,
  input wire logic sysref_i,
  input wire logic sysref_gate_en_i,
  // configuration
  input wire logic [1:0] input_clock_divide_select_i,
  // sample stream
  input wire logic [15:0] sample_i,
  output logic sample_take_o,
  // lane characters
  output jesd_sync_pkg::lane_char_t [1:0] lanes_o,
  output logic frame_start_o,
  // status
  output jesd_sync_pkg::link_phase_t phase_o,
  output logic lmfc_o
);

  // pin synchronisers; sync resets asserted so no alignment precedes release
  logic sync_meta_r;
  logic sync_s_r;
  logic sr_meta_r;
  logic sr_s_r;
  logic sr_prev_r;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_meta_r <= 1'b0;
      sync_s_r <= 1'b0;
      sr_meta_r <= 1'b0;
      sr_s_r <= 1'b0;
      sr_prev_r <= 1'b0;
    end
    else
    begin
      sync_meta_r <= syncb_n_i;
      sync_s_r <= sync_meta_r;
      sr_meta_r <= sysref_i;
      sr_s_r <= sr_meta_r;
      sr_prev_r <= sr_s_r;
    end
  end

  // local multiframe timing and sysref realignment
  logic [7:0] pos_r, pos_nxt;
  logic [7:0] sr_cnt_r, sr_cnt_nxt;
  logic [3:0] tx_sub_r, tx_sub_nxt;
  logic [3:0] tx_frame_r, tx_frame_nxt;
  logic sr_edge;
  logic [7:0] sr_dly;
  logic realign;

  always_comb
  begin
    // gate closed: sysref edges never disturb the boundary
    sr_edge = sr_s_r & ~sr_prev_r & sysref_gate_en_i;
    case (input_clock_divide_select_i)
      jesd_sync_pkg::DIV_BY2: sr_dly = jesd_sync_pkg::SR_DIV2_CYC;
      jesd_sync_pkg::DIV_BY4: sr_dly = jesd_sync_pkg::SR_DIV4_CYC;
      default: sr_dly = jesd_sync_pkg::SR_DIV1_CYC;
    endcase
    sr_cnt_nxt = sr_cnt_r;
    realign = 1'b0;
    if (sr_edge)
    begin
      sr_cnt_nxt = sr_dly;
    end
    else if (sr_cnt_r != 8'h00)
    begin
      sr_cnt_nxt = sr_cnt_r - 8'h01;
      realign = (sr_cnt_r == 8'h01);
    end
    pos_nxt = (pos_r == jesd_sync_pkg::MF_LAST_POS) ? 8'h00 : pos_r + 8'h01;
    tx_sub_nxt = (tx_sub_r == jesd_sync_pkg::FRAME_LAST) ? 4'h0
                                                         : tx_sub_r + 4'h1;
    tx_frame_nxt = tx_frame_r;
    if (tx_sub_r == jesd_sync_pkg::FRAME_LAST)
    begin
      tx_frame_nxt = tx_frame_r + 4'h1;
    end
    if (realign)
    begin
      // keep the transmit grid at the fixed offset from the new boundary
      pos_nxt = 8'h00;
      tx_sub_nxt = jesd_sync_pkg::TX_REALIGN_SUB;
      tx_frame_nxt = jesd_sync_pkg::TX_REALIGN_FRAME;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pos_r <= 8'h00;
      sr_cnt_r <= 8'h00;
      tx_sub_r <= jesd_sync_pkg::TX_REALIGN_SUB;
      tx_frame_r <= jesd_sync_pkg::TX_REALIGN_FRAME;
    end
    else
    begin
      pos_r <= pos_nxt;
      sr_cnt_r <= sr_cnt_nxt;
      tx_sub_r <= tx_sub_nxt;
      tx_frame_r <= tx_frame_nxt;
    end
  end

  // link phase control
  jesd_sync_pkg::link_phase_t phase_r, phase_nxt;
  logic go_ila_r, go_ila_nxt;
  logic resync_r, resync_nxt;
  logic [7:0] low_cnt_r, low_cnt_nxt;
  logic [1:0] ila_mf_r, ila_mf_nxt;
  logic [1:0] div_r, div_nxt;
  logic lmfc_tick;
  logic tx_frame_tick;
  logic tx_mf_tick;

  always_comb
  begin
    lmfc_tick = (pos_r == 8'h00);
    tx_frame_tick = (tx_sub_r == 4'h0);
    // launch point sits 6.6 frames behind the local boundary
    tx_mf_tick = tx_frame_tick && (tx_frame_r == 4'h0);
    phase_nxt = phase_r;
    ila_mf_nxt = ila_mf_r;
    div_nxt = input_clock_divide_select_i;
    go_ila_nxt = go_ila_r;
    // sync seen only at the boundary; missed setup just costs a multiframe
    if (lmfc_tick)
    begin
      go_ila_nxt = sync_s_r;
    end
    low_cnt_nxt = low_cnt_r;
    if (sync_s_r)
    begin
      low_cnt_nxt = 8'h00;
    end
    else if (low_cnt_r != jesd_sync_pkg::RESYNC_CYC)
    begin
      low_cnt_nxt = low_cnt_r + 8'h01;
    end
    resync_nxt = resync_r;
    if (tx_mf_tick && resync_r)
    begin
      resync_nxt = 1'b0;
    end
    // a request arriving with the clear is kept: set wins
    if ((phase_r != jesd_sync_pkg::PH_CGS &&
         low_cnt_r == jesd_sync_pkg::RESYNC_CYC) ||
        div_r != input_clock_divide_select_i)
    begin
      resync_nxt = 1'b1;
    end
    if (tx_mf_tick)
    begin
      if (resync_r)
      begin
        phase_nxt = jesd_sync_pkg::PH_CGS;
      end
      else
      begin
        case (phase_r)
          jesd_sync_pkg::PH_CGS:
          begin
            if (go_ila_r)
            begin
              phase_nxt = jesd_sync_pkg::PH_ILA;
              ila_mf_nxt = 2'h0;
            end
          end
          jesd_sync_pkg::PH_ILA:
          begin
            if (ila_mf_r == jesd_sync_pkg::ILA_LAST_MF)
            begin
              phase_nxt = jesd_sync_pkg::PH_DATA;
            end
            else
            begin
              ila_mf_nxt = ila_mf_r + 2'h1;
            end
          end
          jesd_sync_pkg::PH_DATA: phase_nxt = jesd_sync_pkg::PH_DATA;
          default: phase_nxt = jesd_sync_pkg::PH_CGS;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      phase_r <= jesd_sync_pkg::PH_CGS;
      go_ila_r <= 1'b0;
      resync_r <= 1'b0;
      low_cnt_r <= 8'h00;
      ila_mf_r <= 2'h0;
      div_r <= jesd_sync_pkg::DIV_BY1;
    end
    else
    begin
      phase_r <= phase_nxt;
      go_ila_r <= go_ila_nxt;
      resync_r <= resync_nxt;
      low_cnt_r <= low_cnt_nxt;
      ila_mf_r <= ila_mf_nxt;
      div_r <= div_nxt;
    end
  end

  // lane output register, loaded on each transmit frame start
  jesd_sync_pkg::lane_char_t [1:0] gen_chars;
  jesd_sync_pkg::lane_char_t [1:0] lanes_r, lanes_nxt;
  logic frame_start_r, frame_start_nxt;
  logic lmfc_r, lmfc_nxt;

  ila_char_gen u_char_gen
  (
    .phase_i(phase_nxt),
    .ila_mf_i(ila_mf_nxt),
    .frame_i(tx_frame_r),
    .sample_i(sample_i),
    .chars_o(gen_chars)
  );

  always_comb
  begin
    // phase_nxt is used so a phase change lands on its own first frame
    lanes_nxt = tx_frame_tick ? gen_chars : lanes_r;
    frame_start_nxt = tx_frame_tick;
    lmfc_nxt = lmfc_tick;
    sample_take_o = tx_frame_tick && (phase_nxt == jesd_sync_pkg::PH_DATA);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lanes_r <= '0;
      frame_start_r <= 1'b0;
      lmfc_r <= 1'b0;
    end
    else
    begin
      lanes_r <= lanes_nxt;
      frame_start_r <= frame_start_nxt;
      lmfc_r <= lmfc_nxt;
    end
  end

  assign lanes_o = lanes_r;
  assign frame_start_o = frame_start_r;
  assign lmfc_o = lmfc_r;
  assign phase_o = phase_r;

endmodule
`default_nettype wire

// file: testbench/jesd_link_sync_timing_assertions.sv
// checker for the link sync timing block, top ports only
// assumes a 10-cycle frame and a 160-cycle multiframe
`timescale 1ns/1ps
`default_nettype none
module jesd_link_sync_timing_assertions
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // link pins and configuration
  input wire logic syncb_n_i,
  input wire logic sysref_i,
  input wire logic sysref_gate_en_i,
  input wire logic [1:0] input_clock_divide_select_i,
  // stream and status
  input wire logic [15:0] sample_i,
  input wire logic sample_take_o,
  input wire jesd_sync_pkg::lane_char_t [1:0] lanes_o,
  input wire logic frame_start_o,
  input wire jesd_sync_pkg::link_phase_t phase_o,
  input wire logic lmfc_o
);
  int sl_r;
  int low_r;
  int sl;
  logic seen_r;
  // cycles since the last boundary pulse, zero on the pulse itself
  assign sl = lmfc_o ? 0 : sl_r;
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sl_r <= 0;
      low_r <= 0;
      seen_r <= 1'b0;
    end
    else
    begin
      sl_r <= sl + 1;
      low_r <= syncb_n_i ? 0 : low_r + 1;
      seen_r <= seen_r | lmfc_o;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_mf_open;
    frame_start_o && lanes_o[0] == {1'b1, jesd_sync_pkg::K_MF_START};
  endsequence
  sequence s_mf_close;
    frame_start_o && lanes_o[0] == {1'b1, jesd_sync_pkg::K_MF_END};
  endsequence
  a_frame_grid: assert property
    (frame_start_o && seen_r |-> sl % 10 == 6)
    else $error("frame start off the frame grid");
  a_lmfc_period: assert property
    (lmfc_o && seen_r && !sysref_gate_en_i |-> sl_r == 160)
    else $error("boundary period is not one multiframe");
  a_sysref_align: assert property
    ($rose(sysref_i) && sysref_gate_en_i &&
    input_clock_divide_select_i == jesd_sync_pkg::DIV_BY1 |-> ##[42:46] lmfc_o)
    else $error("sysref did not realign the boundary");
  a_cgs_commas: assert property (frame_start_o &&
    phase_o == jesd_sync_pkg::PH_CGS && $past(phase_o) == jesd_sync_pkg::PH_CGS
    |-> lanes_o[0] == {1'b1, jesd_sync_pkg::K_COMMA}
    && lanes_o[1] == {1'b1, jesd_sync_pkg::K_COMMA})
    else $error("comma expected during code group sync");
  a_ila_start: assert property (s_mf_open |-> sl == 66)
    else $error("alignment multiframe not 66 cycles after boundary");
  a_ila_mf_end: assert property (s_mf_open |-> ##150 s_mf_close)
    else $error("alignment multiframe does not close with A");
  a_ila_length: assert property
    ($rose(phase_o == jesd_sync_pkg::PH_DATA)
    |-> $past(phase_o, 640) == jesd_sync_pkg::PH_ILA
    && $past(phase_o, 641) != jesd_sync_pkg::PH_ILA)
    else $error("alignment phase is not four multiframes");
  a_data_grid: assert property (sample_take_o |-> sl % 10 == 5)
    else $error("sample taken off the frame grid");
  a_data_pair: assert property (sample_take_o |=> frame_start_o
    && {lanes_o[0].d, lanes_o[1].d} == $past(sample_i))
    else $error("lanes do not carry the taken sample");
  a_resync_cgs: assert property (low_r == 45 &&
    phase_o != jesd_sync_pkg::PH_CGS |->
    ##[1:170] phase_o == jesd_sync_pkg::PH_CGS)
    else $error("held sync request did not restart the link");
endmodule
bind jesd_link_sync_timing jesd_link_sync_timing_assertions chk_u (
  .mclk_i, .arst_n_i, .syncb_n_i, .sysref_i, .sysref_gate_en_i,
  .input_clock_divide_select_i, .sample_i, .sample_take_o, .lanes_o,
  .frame_start_o, .phase_o, .lmfc_o);
`default_nettype wire

// file: testbench/rx_sync_model.sv
// receiver-side model driving the sync pin of the link
// assumes lmfc_i is the device boundary pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module rx_sync_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control from the bench
  input wire logic lmfc_i,
  input wire logic want_i,
  input wire logic late_i,
  // sync pin, low requests commas
  output logic syncb_n_o
);
  int low_r;
  int since_r;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      syncb_n_o <= 1'b0;
      low_r <= 0;
      since_r <= 0;
    end
    else
    begin
      since_r <= lmfc_i ? 0 : since_r + 1;
      low_r <= syncb_n_o ? 0 : low_r + 1;
      if (want_i)
        syncb_n_o <= 1'b0;
      else if (low_r >= 40)
      begin
        // right after the boundary: widest setup, no hold needed
        if (!late_i && lmfc_i)
          syncb_n_o <= 1'b1;
        // late mode misses the setup window on purpose
        if (late_i && since_r == 157)
          syncb_n_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_jesd_link_sync_timing.sv
// self-checking bench for the link sync timing block
// assumes the receiver model on the sync pin and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_jesd_link_sync_timing;
  localparam logic [8:0] COM = {1'b1, jesd_sync_pkg::K_COMMA};
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sysref = 1'b0;
  logic gate = 1'b0;
  logic want = 1'b1;
  logic late = 1'b0;
  logic [1:0] div = jesd_sync_pkg::DIV_BY1;
  logic [15:0] sample = 16'hA55A;
  logic syncb_n;
  logic take;
  logic fs;
  logic lmfc;
  jesd_sync_pkg::lane_char_t [1:0] lanes;
  jesd_sync_pkg::link_phase_t ph;
  int n_errors = 0;
  int check_count = 0;
  always #50 mclk_i = ~mclk_i;
  jesd_link_sync_timing dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .syncb_n_i(syncb_n), .sysref_i(sysref), .sysref_gate_en_i(gate),
    .input_clock_divide_select_i(div), .sample_i(sample),
    .sample_take_o(take), .lanes_o(lanes), .frame_start_o(fs),
    .phase_o(ph), .lmfc_o(lmfc));
  rx_sync_model rx_u (.clk_i(mclk_i), .rst_n_i(arst_n_i), .lmfc_i(lmfc),
    .want_i(want), .late_i(late), .syncb_n_o(syncb_n));
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task tick;
    @(posedge mclk_i);
    #1;
  endtask
  // a bound that runs out ends the run at once
  task lim(input int c, input int n);
    if (c >= n)
    begin
      ck(1'b0, "wait timed out");
      close_out;
    end
  endtask
  task automatic wait_fs;
    int c;
    for (c = 0; c < 200 && fs !== 1'b1; c++)
      tick;
    lim(c, 200);
  endtask
  task automatic t_cgs;
    wait_fs;
    ck(lanes[0] === COM && lanes[1] === COM, "no comma after reset");
    ck(ph === jesd_sync_pkg::PH_CGS, "phase not sync after reset");
    repeat (100) tick;
    ck(ph === jesd_sync_pkg::PH_CGS, "alignment with sync held low");
    $display("t_cgs done");
  endtask
  task automatic t_sysref(input logic g, input logic [1:0] d, input int dly);
    int c;
    for (c = 0; c < 200 && lmfc !== 1'b1; c++)
      tick;
    lim(c, 200);
    repeat (50) tick;
    @(posedge mclk_i);
    sysref <= 1'b1;
    gate <= g;
    div <= d;
    for (c = 1; c < 200; c++)
    begin
      @(posedge mclk_i);
      if (c == 25)
        sysref <= 1'b0;
      #1;
      if (lmfc === 1'b1)
        break;
    end
    if (g)
      ck(c >= dly + 2 && c <= dly + 6, "sysref realign delay");
    else
      ck(c > 100, "gated sysref moved the boundary");
    @(posedge mclk_i);
    gate <= 1'b0;
    div <= jesd_sync_pkg::DIV_BY1;
    $display("t_sysref done");
  endtask
  task automatic t_link(input logic lt, input int nb);
    int c;
    int nl;
    nl = 0;
    @(posedge mclk_i);
    late <= lt;
    want <= 1'b0;
    for (c = 0; c < 800; c++)
    begin
      tick;
      if (lmfc === 1'b1 && syncb_n === 1'b1)
        nl++;
      if (fs === 1'b1 && lanes[0] === {1'b1, jesd_sync_pkg::K_MF_START})
        break;
    end
    lim(c, 800);
    ck(nl == nb, "alignment started in wrong multiframe");
    ck(ph === jesd_sync_pkg::PH_ILA, "phase not alignment");
    repeat (170) tick;
    ck(lanes[0] === {1'b1, jesd_sync_pkg::K_CFG_START}, "no Q");
    repeat (10) tick;
    ck(lanes[0] === {1'b0, jesd_sync_pkg::CFG_DEV_ID}, "bad cfg");
    for (c = 180; c < 900 && take !== 1'b1; c++)
      tick;
    lim(c, 900);
    ck(c == 639, "alignment length");
    tick;
    ck(fs === 1'b1, "no frame start with first data");
    ck(lanes[0] === {1'b0, sample[15:8]}, "lane 0 data");
    ck(lanes[1] === {1'b0, sample[7:0]}, "lane 1 data");
    $display("t_link done");
  endtask
  task automatic t_resync;
    int c;
    @(posedge mclk_i);
    want <= 1'b1;
    for (c = 0; c < 300 && ph !== jesd_sync_pkg::PH_CGS; c++)
      tick;
    lim(c, 300);
    ck(c >= 40, "resync taken too early");
    wait_fs;
    ck(lanes[0] === COM && lanes[1] === COM, "no comma on resync");
    $display("t_resync done");
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_cgs;
    t_sysref(1'b0, jesd_sync_pkg::DIV_BY1, 0);
    t_sysref(1'b1, jesd_sync_pkg::DIV_BY1, jesd_sync_pkg::SR_DIV1_CYC);
    t_sysref(1'b1, jesd_sync_pkg::DIV_BY2, jesd_sync_pkg::SR_DIV2_CYC);
    t_sysref(1'b1, jesd_sync_pkg::DIV_BY4, jesd_sync_pkg::SR_DIV4_CYC);
    t_link(1'b0, 1);
    t_resync;
    t_link(1'b1, 2);
    close_out;
  end
endmodule
`default_nettype wire
